// ### logic/wdm_pkg.sv
`default_nettype none

package wdm_pkg;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int CNT_W = 21;
  localparam logic [7:0] CTRL_ADDR = 8'h60;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RDATA_ZERO = 8'h00;
  localparam int UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES - 1);
  localparam logic [2:0] UNLOCK_DONE = 3'h0;
  localparam logic [3:0] PERIOD_MAX = 4'h9;
  localparam logic [CNT_W-1:0] PERIOD_BASE = 21'h000800;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic FUSE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    WDM_STOPPED = 4'h1,
    WDM_IRQ = 4'h2,
    WDM_RST = 4'h4,
    WDM_IRQ_RST = 4'h8
  } wdm_mode_e;

  // Control and status byte, bit 7 down to bit 0.
  typedef struct packed {
    logic irq_flag;
    logic irq_enable;
    logic period_msb;
    logic change_unlock;
    logic reset_enable;
    logic [2:0] period_low;
  } wdm_ctrl_s;

  // Timeout length in oscillator cycles; reserved codes act as the longest.
  function automatic logic [CNT_W-1:0] wdm_timeout_limit(
    input logic [3:0] sel
  );
    logic [3:0] s;
    s = (sel > PERIOD_MAX) ? PERIOD_MAX : sel;
    return PERIOD_BASE << s;
  endfunction : wdm_timeout_limit

endpackage : wdm_pkg

`default_nettype wire

// ### logic/wdm_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wdm_counter
  import wdm_pkg::*;
#(
  parameter int W = CNT_W
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Oscillator and control
  input wire logic osc_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [W-1:0] limit_i,
  // Status
  output logic timeout_o,
  output logic [W-1:0] count_o
);

  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  wire tick;
  wire at_limit;

  // ----------------------------------------------------------------
  // Oscillator edge detection and count
  // ----------------------------------------------------------------
  assign tick = osc_s2 & ~osc_s3;
  assign at_limit = count >= W'(limit_i - W'(1));
  assign timeout_o = run_i & tick & at_limit & ~restart_i;
  assign count_o = count;
  assign next_count = (restart_i | ~run_i | timeout_o) ? '0 :
                      tick ? W'(count + W'(1)) : count;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      count <= '0;
    end
    else
    begin
      osc_s1 <= osc_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RESTART: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    restart_i |=> (count_o == '0) ##1 (count_o <= W'(1)))
    else $error("Counter did not restart.");

  AST_NO_TICK_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (run_i && !tick && !restart_i && !timeout_o) |=> $stable(count_o))
    else $error("Counter moved without an oscillator edge.");

endmodule : wdm_counter

`default_nettype wire

// ### logic/wdm_top.sv
`timescale 1ns/1ps
`default_nettype none

module wdm_top
  import wdm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Processor side
  input wire logic gie_i,
  input wire logic irq_ack_i,
  input wire logic wdr_i,
  input wire logic wdog_reset_cause_flag_i,
  // Oscillator and fuse pins
  input wire logic osc_i,
  input wire logic wdog_force_on_fuse_i,
  // Outputs
  output logic irq_o,
  output logic sys_reset_req_o
);

  logic fuse_s1;
  logic fuse_s2;
  wdm_ctrl_s ctrl;
  wdm_ctrl_s next_ctrl;
  logic [2:0] unlock_cnt;
  logic [2:0] next_unlock_cnt;
  logic timeout;
  logic [CNT_W-1:0] count;
  wdm_mode_e mode;
  wdm_ctrl_s wr;
  wire forced;
  wire addr_hit;
  wire wr_hit;
  wire [3:0] period;
  wire [3:0] wr_period;
  wire [3:0] next_period;
  wire [CNT_W-1:0] limit;
  wire run;
  wire ack;
  wire unlock_start;
  wire set_flag;
  wire do_reset;
  wire next_irq;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign forced = (fuse_s2 == FUSE_PROGRAMMED);
  assign addr_hit = (reg_addr_i == CTRL_ADDR);
  assign wr_hit = reg_wr_i & addr_hit;
  assign wr = wdm_ctrl_s'(reg_wdata_i);
  assign period = {ctrl.period_msb, ctrl.period_low};
  assign wr_period = {wr.period_msb, wr.period_low};
  assign limit = wdm_timeout_limit(period);
  assign mode = forced ? WDM_RST :
                (ctrl.reset_enable & ctrl.irq_enable) ? WDM_IRQ_RST :
                ctrl.reset_enable ? WDM_RST :
                ctrl.irq_enable ? WDM_IRQ : WDM_STOPPED;
  assign run = (mode != WDM_STOPPED);
  assign ack = irq_ack_i & irq_o;

  // ----------------------------------------------------------------
  // Timeout actions
  // ----------------------------------------------------------------
  assign set_flag = timeout & ((mode == WDM_IRQ) |
                    ((mode == WDM_IRQ_RST) & ~ctrl.irq_flag));
  assign do_reset = timeout & ((mode == WDM_RST) |
                    ((mode == WDM_IRQ_RST) & ctrl.irq_flag));

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  assign next_ctrl.irq_flag = set_flag | (ctrl.irq_flag &
                              ~(wr_hit & wr.irq_flag) & ~ack);
  assign next_ctrl.irq_enable = (forced | ack) ? 1'b0 :
                                wr_hit ? wr.irq_enable : ctrl.irq_enable;
  assign next_ctrl.reset_enable =
    (forced | wdog_reset_cause_flag_i) ? 1'b1 :
    ~wr_hit ? ctrl.reset_enable :
    ctrl.change_unlock ? wr.reset_enable :
    (ctrl.reset_enable | wr.reset_enable);
  assign next_period = (wr_hit & ctrl.change_unlock) ? wr_period :
                       period;
  assign next_ctrl.period_msb = next_period[3];
  assign next_ctrl.period_low = next_period[2:0];
  assign unlock_start = wr_hit & wr.change_unlock;
  assign next_ctrl.change_unlock = unlock_start |
    (ctrl.change_unlock & (unlock_cnt != UNLOCK_DONE));
  assign next_unlock_cnt = unlock_start ? UNLOCK_LOAD :
    (unlock_cnt != UNLOCK_DONE) ? 3'(unlock_cnt - 3'h1) : UNLOCK_DONE;
  assign next_irq = next_ctrl.irq_flag & next_ctrl.irq_enable &
                    gie_i;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fuse_s1 <= FUSE_RESET;
      fuse_s2 <= FUSE_RESET;
      ctrl <= wdm_ctrl_s'(CTRL_RESET);
      unlock_cnt <= UNLOCK_DONE;
      irq_o <= 1'b0;
      sys_reset_req_o <= 1'b0;
      reg_rdata_o <= RDATA_ZERO;
    end
    else
    begin
      fuse_s1 <= wdog_force_on_fuse_i;
      fuse_s2 <= fuse_s1;
      ctrl <= next_ctrl;
      unlock_cnt <= next_unlock_cnt;
      irq_o <= next_irq;
      sys_reset_req_o <= do_reset;
      reg_rdata_o <= addr_hit ? ctrl : RDATA_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------
  wdm_counter #(
    .W(CNT_W)
  ) u_counter (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .osc_i(osc_i),
    .run_i(run),
    .restart_i(wdr_i),
    .limit_i(limit),
    .timeout_o(timeout),
    .count_o(count)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_IRQ_GATE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    irq_o |-> $past(gie_i) && ctrl.irq_enable && ctrl.irq_flag)
    else $error("Interrupt raised without both enables.");

  AST_IRQ_MODE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (timeout && mode == WDM_IRQ) |=> ctrl.irq_flag && !sys_reset_req_o)
    else $error("Interrupt mode timeout handled wrongly.");

  AST_FIRST_TIMEOUT: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (timeout && mode == WDM_IRQ_RST && !ctrl.irq_flag)
      |=> ctrl.irq_flag && !sys_reset_req_o)
    else $error("First combined timeout did not set the flag only.");

  AST_ACK_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (ack && !timeout) |=> !ctrl.irq_flag && !ctrl.irq_enable)
    else $error("Vector taken did not clear enable and flag.");

  AST_SECOND_TIMEOUT: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (timeout && mode == WDM_IRQ_RST && ctrl.irq_flag) |=> sys_reset_req_o)
    else $error("Unserviced combined timeout did not reset.");

  AST_STOPPED: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (mode == WDM_STOPPED) |-> !timeout ##1 !sys_reset_req_o)
    else $error("Stopped watchdog took action.");

  AST_STOP_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (mode == WDM_STOPPED) |=> (count == '0))
    else $error("Stopped watchdog kept counting.");

  AST_FORCED: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (forced && timeout) |=> sys_reset_req_o && !ctrl.irq_enable)
    else $error("Forced mode did not reset on timeout.");

  AST_LOCKED: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr_hit && !ctrl.change_unlock)
      |=> $stable(period) && !$fell(ctrl.reset_enable))
    else $error("Locked setting changed without unlock.");

  AST_UNLOCK_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    unlock_start |=> ctrl.change_unlock [*4])
    else $error("Unlock window shorter than four cycles.");

  AST_UNLOCK_END: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (unlock_start ##1 !unlock_start [*4]) |=> !ctrl.change_unlock)
    else $error("Unlock did not clear after four cycles.");

  AST_CAUSE_HOLD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wdog_reset_cause_flag_i |=> ctrl.reset_enable)
    else $error("Reset enable cleared while cause flag set.");

  AST_W1C: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr_hit && wr.irq_flag && !set_flag) |=> !ctrl.irq_flag)
    else $error("Writing one did not clear the flag.");

  COV_COMBINED_IRQ: cover property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (mode == WDM_IRQ_RST) && set_flag);

  COV_RESET: cover property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    sys_reset_req_o);

  COV_UNLOCK_CHANGE: cover property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    unlock_start ##[1:4] (wr_hit && !wr.reset_enable));

  COV_ACK: cover property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ack);

endmodule : wdm_top

`default_nettype wire

// ### testbench/watchdog_mode_prescale_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module watchdog_mode_prescale_control_tb;
  import wdm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_i;
  logic sys_rst_i;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic gie_i;
  logic irq_ack_i;
  logic wdr_i;
  logic wdog_reset_cause_flag_i;
  logic osc_i;
  logic wdog_force_on_fuse_i;
  logic irq_o;
  logic sys_reset_req_o;
  int num_errors;
  int compares;
  int n_rst;
  int n;

  wdm_top u_dut (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .gie_i(gie_i),
    .irq_ack_i(irq_ack_i),
    .wdr_i(wdr_i),
    .wdog_reset_cause_flag_i(wdog_reset_cause_flag_i),
    .osc_i(osc_i),
    .wdog_force_on_fuse_i(wdog_force_on_fuse_i),
    .irq_o(irq_o),
    .sys_reset_req_o(sys_reset_req_o)
  );

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // The watchdog oscillator runs at one eighth of the system clock.
  initial
  begin
    osc_i = 1'b0;
    forever #40 osc_i = ~osc_i;
  end

  always @(posedge clk_sys_i)
    if (sys_reset_req_o === 1'b1)
      n_rst++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    reg_addr_i = CTRL_ADDR;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    #1;
    reg_addr_i = a;
    @(posedge clk_sys_i);
    #1;
    check(reg_rdata_o, exp);
  endtask : rd

  task automatic pulse_restart();
    @(posedge clk_sys_i);
    #1;
    wdr_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    wdr_i = 1'b0;
  endtask : pulse_restart

  // Waits for the interrupt or, with rst_ev set, the reset request.
  task automatic wait_ev(input bit rst_ev, output int cnt);
    cnt = 0;
    while (((rst_ev ? sys_reset_req_o : irq_o) !== 1'b1) && cnt < 20000)
    begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end
    if (cnt >= 20000)
    begin
      num_errors++;
      close_out();
    end
  endtask : wait_ev

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    compares = 0;
    n_rst = 0;
    sys_rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    gie_i = 1'b0;
    irq_ack_i = 1'b0;
    wdr_i = 1'b0;
    wdog_reset_cause_flag_i = 1'b0;
    wdog_force_on_fuse_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(CTRL_ADDR, CTRL_RESET);
    rd(8'h61, RDATA_ZERO);
    wr(8'h05);
    rd(CTRL_ADDR, 8'h00);
    wr(8'h08);
    rd(CTRL_ADDR, 8'h08);
    wr(8'h18);
    wr(8'h05);
    rd(CTRL_ADDR, 8'h15);
    wr(8'h18);
    rd(CTRL_ADDR, 8'h1D);
    repeat (4) @(posedge clk_sys_i);
    rd(CTRL_ADDR, 8'h0D);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h0D);
    wdog_reset_cause_flag_i = 1'b1;
    wr(8'h18);
    wr(8'h00);
    rd(CTRL_ADDR, 8'h18);
    wdog_reset_cause_flag_i = 1'b0;
    wr(8'h18);
    wr(8'h40);
    rd(CTRL_ADDR, 8'h50);
    // Interrupt mode with the global enable off, then on.
    pulse_restart();
    repeat (16500) @(posedge clk_sys_i);
    #1;
    check(irq_o, 1'b0);
    rd(CTRL_ADDR, 8'hC0);
    gie_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(irq_o, 1'b1);
    wr(8'hC0);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(irq_o, 1'b0);
    rd(CTRL_ADDR, 8'h40);
    check(8'(n_rst), 8'h00);
    // Combined mode: interrupt first, reset on the next timeout.
    wr(8'h48);
    pulse_restart();
    wait_ev(1'b0, n);
    check(8'(n >= 16300 && n <= 16450), 8'h01);
    check(8'(n_rst), 8'h00);
    rd(CTRL_ADDR, 8'hC8);
    wait_ev(1'b1, n);
    check(8'(n >= 16200 && n <= 16450), 8'h01);
    @(posedge clk_sys_i);
    #1;
    irq_ack_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    irq_ack_i = 1'b0;
    rd(CTRL_ADDR, 8'h08);
    check(irq_o, 1'b0);
    // Software sets the interrupt enable again to stay in combined mode.
    wr(8'h48);
    rd(CTRL_ADDR, 8'h48);
    // Programmed fuse overrides an interrupt-only setup.
    wr(8'h18);
    wr(8'h40);
    wdog_force_on_fuse_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(CTRL_ADDR, 8'h08);
    pulse_restart();
    wait_ev(1'b1, n);
    check(8'(n >= 16300 && n <= 16450), 8'h01);
    check(irq_o, 1'b0);
    close_out();
  end

endmodule : watchdog_mode_prescale_control_tb

`default_nettype wire
